// ### sim/bhf_dev_model.sv
// bhf_dev_model: behavioural 128 x 8 handshake fifo device
// assumes pins sampled on the bench clock; slow_i stretches the line answers
`timescale 1ns/1ps
module bhf_dev_model
  import bhf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              clear_n_i,
  input  wire logic              dir_i,
  input  wire logic              slow_i,
  input  wire logic              a_ack_n_i,
  input  wire logic              b_ack_n_i,
  input  wire logic              a_drive_en_n_i,
  input  wire logic              b_drive_en_n_i,
  input  wire logic [BYTE_W-1:0] a_bus_i,
  input  wire logic [BYTE_W-1:0] b_bus_i,
  output logic                   a_line_o,
  output logic                   b_line_o,
  output logic      [BYTE_W-1:0] data_o,
  output logic                   a_oe_o,
  output logic                   b_oe_o,
  output logic                   empty_o,
  output logic                   full_o
);
  logic [BYTE_W-1:0] mem [FIFO_DEPTH];
  logic [6:0]        wp;
  logic [6:0]        rp;
  logic [7:0]        cnt;
  logic [2:0]        tick = 3'h0;
  logic              rdy;
  logic              avail_n;
  logic              in_q;
  logic              out_q;
  wire               in_ack_n  = dir_i ? b_ack_n_i : a_ack_n_i;
  wire               out_ack_n = dir_i ? a_ack_n_i : b_ack_n_i;
  wire               push      = clear_n_i && rdy && in_q && !in_ack_n;
  wire               pop       = clear_n_i && !avail_n && out_q && !out_ack_n;
  wire               go        = !slow_i || tick == 3'h0;
  always_ff @(posedge clk_i)
  begin
    tick <= tick + 3'h1;
    in_q <= in_ack_n;
    out_q <= out_ack_n;
  end
  always_ff @(posedge clk_i)
  begin
    if (!clear_n_i)
    begin
      wp <= 7'h00;
      rp <= 7'h00;
      cnt <= 8'h00;
      rdy <= 1'b1;
      avail_n <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem[wp] <= dir_i ? b_bus_i : a_bus_i;
        wp <= wp + 7'h01;
        rdy <= 1'b0;
      end
      else if (!rdy && in_ack_n && go && cnt != 8'h80)
        rdy <= 1'b1;
      if (pop)
      begin
        rp <= rp + 7'h01;
        avail_n <= 1'b1;
      end
      else if (avail_n && out_ack_n && go && cnt != 8'h00)
        avail_n <= 1'b0;
      cnt <= cnt + {7'h00, push} - {7'h00, pop};
    end
  end
  assign a_line_o = !clear_n_i || (dir_i ? avail_n : rdy);
  assign b_line_o = !clear_n_i || (dir_i ? rdy : avail_n);
  assign data_o   = mem[rp];
  assign a_oe_o   = dir_i && !a_drive_en_n_i;
  assign b_oe_o   = !dir_i && !b_drive_en_n_i;
  assign empty_o  = !clear_n_i || cnt == 8'h00;
  assign full_o   = clear_n_i && cnt == 8'h80;
endmodule : bhf_dev_model

// ### sim/bhf_host_chk.sv
// bhf_host_chk: pin-level checks on the fifo host controller
// assumes it is bound to bhf_host; every pin is in the ref_clk_i domain
`timescale 1ns/1ps
module bhf_host_chk
  import bhf_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              fifo_clear_n_o,
  input  wire logic              fifo_dir_o,
  input  wire logic              a_ack_n_o,
  input  wire logic              a_line_i,
  input  wire logic [BYTE_W-1:0] a_data_o,
  input  wire logic              a_data_oe_o,
  input  wire logic              a_drive_en_n_o,
  input  wire logic              b_ack_n_o,
  input  wire logic              b_line_i,
  input  wire logic              b_drive_en_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] clr_low;
  logic [6:0] a_gap;
  logic       a_q;
  // cycles spent with clear held low
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || fifo_clear_n_o)
      clr_low <= 6'h00;
    else if (clr_low != 6'h3F)
      clr_low <= clr_low + 6'h01;
  end
  // cycles since the last port a acknowledge fall
  always_ff @(posedge ref_clk_i)
  begin
    a_q <= a_ack_n_o;
    if (rst_i)
      a_gap <= 7'h7F;
    else if (a_q && !a_ack_n_o)
      a_gap <= 7'h00;
    else if (a_gap != 7'h7F)
      a_gap <= a_gap + 7'h01;
  end
  AST_CLR_WIDTH: assert property ($rose(fifo_clear_n_o) |-> clr_low >= 6'h23)
    else $error("clear released too early");
  AST_DIR_IN_CLEAR: assert property ($changed(fifo_dir_o) |-> !fifo_clear_n_o)
    else $error("direction changed outside clear");
  AST_DIR_SETTLE: assert property ($rose(fifo_clear_n_o) |-> $past(fifo_dir_o, 3) == fifo_dir_o)
    else $error("direction not settled before clear release");
  AST_A_ACK_READY: assert property ($fell(a_ack_n_o) && !fifo_dir_o |-> $past(a_line_i))
    else $error("input acknowledge without ready");
  AST_A_SETUP: assert property ($fell(a_ack_n_o) && !fifo_dir_o |-> $past(a_data_oe_o, 3))
    else $error("input data not set up before acknowledge");
  AST_A_HOLD: assert property (!a_ack_n_o && !fifo_dir_o |-> a_data_oe_o && $stable(a_data_o))
    else $error("input data moved while acknowledge low");
  AST_A_ACK_HELD: assert property (!a_ack_n_o && a_line_i && !fifo_dir_o && fifo_clear_n_o |=> !a_ack_n_o)
    else $error("input acknowledge dropped before device answer");
  AST_B_ACK_AVAIL: assert property ($fell(b_ack_n_o) && !fifo_dir_o |->
    !$past(b_line_i) && $past(b_drive_en_n_o, 8) == 1'b0)
    else $error("output acknowledge without byte or drive time");
  AST_B_ACK_HELD: assert property (!b_ack_n_o && !b_line_i && !fifo_dir_o && fifo_clear_n_o |=> !b_ack_n_o)
    else $error("output acknowledge dropped early");
  AST_ACK_GAP: assert property ($fell(a_ack_n_o) |-> a_gap >= 7'h31)
    else $error("acknowledges closer than one microsecond");
  AST_NO_ACK_CLEAR: assert property (!fifo_clear_n_o && $past(fifo_clear_n_o) == 1'b0 |-> a_ack_n_o && b_ack_n_o)
    else $error("acknowledge during clear");
  AST_INPUT_OE_OFF: assert property (!fifo_dir_o |-> a_drive_en_n_o)
    else $error("input port drivers enabled");
endmodule : bhf_host_chk

bind bhf_host bhf_host_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .fifo_clear_n_o(fifo_clear_n_o),
  .fifo_dir_o(fifo_dir_o), .a_ack_n_o(a_ack_n_o), .a_line_i(a_line_i), .a_data_o(a_data_o),
  .a_data_oe_o(a_data_oe_o), .a_drive_en_n_o(a_drive_en_n_o), .b_ack_n_o(b_ack_n_o), .b_line_i(b_line_i),
  .b_drive_en_n_o(b_drive_en_n_o));

// ### sim/tb.sv
// tb: self-checking bench for bhf_host against the behavioural fifo device
// assumes the register map of bhf_pkg; released buses show a changing pattern
`timescale 1ns/1ps
module tb;
  import bhf_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst     = 1'b1;
  logic [ADDR_W-1:0] addr    = 8'h00;
  logic [DATA_W-1:0] wdata   = 32'h0000_0000;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic              slow    = 1'b0;
  logic [7:0]        pat     = 8'h00;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic              irq, clear_n, dir, empty, full, a_ack_n, b_ack_n, a_line, b_line;
  logic              a_oe, b_oe, a_den_n, b_den_n, da_oe, db_oe;
  logic [7:0]        a_hd, b_hd, dev_d, a_bus, b_bus;
  int                bad_count  = 0;
  int                n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pat <= pat + 8'h01;
  assign a_bus = a_oe ? a_hd : (da_oe ? dev_d : pat);
  assign b_bus = b_oe ? b_hd : (db_oe ? dev_d : pat);
  bhf_host u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .fifo_clear_n_o(clear_n), .fifo_dir_o(dir),
    .fifo_empty_i(empty), .fifo_full_i(full), .a_ack_n_o(a_ack_n), .a_line_i(a_line), .a_data_i(a_bus),
    .a_data_o(a_hd), .a_data_oe_o(a_oe), .a_drive_en_n_o(a_den_n), .b_ack_n_o(b_ack_n), .b_line_i(b_line),
    .b_data_i(b_bus), .b_data_o(b_hd), .b_data_oe_o(b_oe), .b_drive_en_n_o(b_den_n));
  bhf_dev_model u_dev (.clk_i(ref_clk), .clear_n_i(clear_n), .dir_i(dir), .slow_i(slow), .a_ack_n_i(a_ack_n),
    .b_ack_n_i(b_ack_n), .a_drive_en_n_i(a_den_n), .b_drive_en_n_i(b_den_n), .a_bus_i(a_bus), .b_bus_i(b_bus),
    .a_line_o(a_line), .b_line_o(b_line), .data_o(dev_d), .a_oe_o(da_oe), .b_oe_o(db_oe), .empty_o(empty),
    .full_o(full));
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rreg
  // poll one status bit, bounded
  task automatic wait_st(input int b, input logic val);
    for (int i = 0; i < 3000; i++)
    begin
      rreg(REG_STATUS, v);
      if (v[b] === val)
        break;
    end
    chk("status bit", {31'h0, val}, {31'h0, v[b]});
  endtask : wait_st
  task automatic send(input logic [7:0] d);
    wait_st(STAT_TX_PEND, 1'b0);
    wreg(REG_TXDATA, {24'h00_0000, d});
  endtask : send
  task automatic recv(input logic [7:0] e);
    wait_st(STAT_RX_VALID, 1'b1);
    rreg(REG_RXDATA, v);
    chk("rx byte", {24'h00_0000, e}, {24'h00_0000, v[7:0]});
  endtask : recv
  task automatic t_boot;
    repeat (45) @(posedge ref_clk);
    wait_st(STAT_CLEARING, 1'b0);
    rreg(REG_STATUS, v);
    chk("status after clear", 32'h0000_0010, v);
    rreg(REG_IRQ_STAT, v);
    chk("irq after clear", 32'h0000_0004, v);
    rreg(REG_IRQ_MASK, v);
    chk("mask reset", 32'h0000_0000, v);
    wreg(8'h20, 32'hFFFF_FFFF);
    rreg(8'h20, v);
    chk("unmapped", 32'h0000_0000, v);
    rreg(REG_CTRL, v);
    chk("ctrl", 32'h0000_0000, {31'h0, v[CTRL_DIR_BIT]});
  endtask : t_boot
  task automatic t_a_to_b;
    wreg(REG_IRQ_STAT, 32'h0000_000F);
    wreg(REG_IRQ_MASK, 32'h0000_0002);
    send(8'h3C);
    send(8'hC3);
    wait_st(STAT_RX_VALID, 1'b1);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    recv(8'h3C);
    recv(8'hC3);
    wreg(REG_IRQ_STAT, 32'h0000_0002);
    @(negedge ref_clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
  endtask : t_a_to_b
  task automatic t_fill;
    wreg(REG_IRQ_MASK, 32'h0000_0000);
    @(posedge ref_clk);
    slow <= 1'b1;
    for (int i = 0; i < 130; i++)
      send(8'(i * 3));
    wait_st(STAT_FULL, 1'b1);
    rreg(REG_STATUS, v);
    chk("status full", 32'h0000_0023, v);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    for (int i = 0; i < 130; i++)
      recv(8'(i * 3));
    wait_st(STAT_TX_PEND, 1'b0);
    rreg(REG_STATUS, v);
    chk("status drained", 32'h0000_0010, v);
    @(posedge ref_clk);
    slow <= 1'b0;
  endtask : t_fill
  task automatic t_dir;
    wreg(REG_CTRL, 32'h0000_0003);
    wait_st(STAT_CLEARING, 1'b0);
    chk("dir pin", 32'h0000_0001, {31'h0, dir});
    send(8'hA1);
    recv(8'hA1);
    send(8'h1A);
    send(8'h77);
    wait_st(STAT_TX_PEND, 1'b0);
    rreg(REG_STATUS, v);
    chk("status reversed", 32'h0000_0006, v);
    wreg(REG_CTRL, 32'h0000_0002);
    wait_st(STAT_CLEARING, 1'b0);
    rreg(REG_RXDATA, v);
    repeat (150) @(posedge ref_clk);
    rreg(REG_STATUS, v);
    chk("status after clear", 32'h0000_0010, v);
  endtask : t_dir
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_boot;
    t_a_to_b;
    t_fill;
    t_dir;
    results;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    results;
  end
endmodule : tb

// ### src/bhf_host.sv
// bhf_host: controller driving an external bidirectional handshake fifo
// assumes pins synchronous to ref_clk_i; the bench resolves shared data and status wires
`timescale 1ns/1ps
module bhf_host
  import bhf_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   irq_o,
  output logic                   fifo_clear_n_o,
  output logic                   fifo_dir_o,
  input  wire logic              fifo_empty_i,
  input  wire logic              fifo_full_i,
  output logic                   a_ack_n_o,
  input  wire logic              a_line_i,
  input  wire logic [BYTE_W-1:0] a_data_i,
  output logic      [BYTE_W-1:0] a_data_o,
  output logic                   a_data_oe_o,
  output logic                   a_drive_en_n_o,
  output logic                   b_ack_n_o,
  input  wire logic              b_line_i,
  input  wire logic [BYTE_W-1:0] b_data_i,
  output logic      [BYTE_W-1:0] b_data_o,
  output logic                   b_data_oe_o,
  output logic                   b_drive_en_n_o
);

  bhf_port_if pa ();
  bhf_port_if pb ();

  bhf_clr_state_type  clr_state;
  logic [CNT_W-1:0]   clr_cnt;
  logic               dir_req;
  logic               clr_done;
  logic               clearing;
  logic               tx_pending;
  logic [BYTE_W-1:0]  tx_byte;
  logic               rx_valid;
  logic [BYTE_W-1:0]  rx_byte;
  logic [IRQ_W-1:0]   irq_mask;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_event;
  logic [IRQ_W-1:0]   irq_clear;
  logic               empty_q;
  logic               tx_done;
  logic               rx_strobe;
  logic [BYTE_W-1:0]  rx_in;
  logic               wr_ctrl;
  logic               wr_tx;
  logic               rd_rx;
  logic [DATA_W-1:0]  next_rdata;

  assign wr_ctrl  = reg_wr_i && (reg_addr_i == REG_CTRL);
  assign wr_tx    = reg_wr_i && (reg_addr_i == REG_TXDATA);
  assign rd_rx    = reg_rd_i && (reg_addr_i == REG_RXDATA);
  assign clearing = (clr_state != CL_IDLE);

  // clear sequence: hold clear low, set direction, release; also run from reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      clr_state      <= CL_LOW;
      clr_cnt        <= CLEAR_CYC;
      fifo_clear_n_o <= 1'b0;
    end
    else
    begin
      unique case (clr_state)
        CL_IDLE:
        begin
          if (wr_ctrl && reg_wdata_i[CTRL_CLEAR_BIT])
          begin
            fifo_clear_n_o <= 1'b0;
            clr_state      <= CL_LOW;
            clr_cnt        <= CLEAR_CYC;
          end
        end
        CL_LOW:
        begin
          if (clr_cnt == CNT_ONE)
          begin
            clr_state  <= CL_DIR;
            clr_cnt    <= SETUP_CYC;
          end
          else
            clr_cnt <= clr_cnt - CNT_ONE;
        end
        CL_DIR:
        begin
          if (clr_cnt == CNT_ONE)
          begin
            fifo_clear_n_o <= 1'b1;
            clr_state      <= CL_IDLE;
          end
          else
            clr_cnt <= clr_cnt - CNT_ONE;
        end
      endcase
    end
  end

  // direction asked for with a clear command
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      dir_req <= 1'b0;
    else if (!clearing && wr_ctrl && reg_wdata_i[CTRL_CLEAR_BIT])
      dir_req <= reg_wdata_i[CTRL_DIR_BIT];
  end

  // fifo is empty by now, so the direction may change
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      fifo_dir_o <= 1'b0;
    else if (clr_state == CL_LOW && clr_cnt == CNT_ONE)
      fifo_dir_o <= dir_req;
  end

  // one pulse as clear is released
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      clr_done <= 1'b0;
    else
      clr_done <= (clr_state == CL_DIR) && (clr_cnt == CNT_ONE);
  end

  // port roles follow the direction pin; engines idle while clear is low
  assign pa.enable      = fifo_clear_n_o && !clearing;
  assign pb.enable      = fifo_clear_n_o && !clearing;
  assign pa.source_role = !fifo_dir_o;
  assign pb.source_role = fifo_dir_o;
  assign pa.tx_valid    = tx_pending;
  assign pb.tx_valid    = tx_pending;
  assign pa.tx_data     = tx_byte;
  assign pb.tx_data     = tx_byte;
  assign pa.rx_ready    = !rx_valid;
  assign pb.rx_ready    = !rx_valid;
  assign pa.line        = a_line_i;
  assign pb.line        = b_line_i;
  assign pa.data_in     = a_data_i;
  assign pb.data_in     = b_data_i;

  assign a_ack_n_o      = pa.ack_n;
  assign a_data_o       = pa.data_out;
  assign a_data_oe_o    = pa.data_oe;
  assign a_drive_en_n_o = pa.drive_en_n;
  assign b_ack_n_o      = pb.ack_n;
  assign b_data_o       = pb.data_out;
  assign b_data_oe_o    = pb.data_oe;
  assign b_drive_en_n_o = pb.drive_en_n;

  bhf_hs_port u_port_a (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .port      (pa.engine)
  );

  bhf_hs_port u_port_b (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .port      (pb.engine)
  );

  assign tx_done   = pa.tx_done | pb.tx_done;
  assign rx_strobe = pa.rx_strobe | pb.rx_strobe;
  assign rx_in     = fifo_dir_o ? pa.rx_data : pb.rx_data;

  // transmit holding byte; a write while one is pending is dropped unless tx_done ends that byte in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tx_pending <= 1'b0;
      tx_byte    <= BYTE_ZERO;
    end
    else if (wr_tx && (!tx_pending || tx_done))
    begin
      tx_pending <= 1'b1;
      tx_byte    <= reg_wdata_i[BYTE_W-1:0];
    end
    else if (tx_done)
      tx_pending <= 1'b0;
  end

  // receive holding byte; while full the engine holds off acknowledging
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rx_valid <= 1'b0;
      rx_byte  <= BYTE_ZERO;
    end
    else if (rx_strobe)
    begin
      rx_valid <= 1'b1;
      rx_byte  <= rx_in;
    end
    else if (rd_rx)
      rx_valid <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      irq_mask <= IRQ_ZERO;
    else if (reg_wr_i && reg_addr_i == REG_IRQ_MASK)
      irq_mask <= reg_wdata_i[IRQ_W-1:0];
  end

  // empty rise detector on the wire-ored status line
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      empty_q <= 1'b1;
    else
      empty_q <= fifo_empty_i;
  end

  always_comb
  begin
    irq_event               = IRQ_ZERO;
    irq_event[IRQ_TX_DONE]  = tx_done;
    irq_event[IRQ_RX_AVAIL] = rx_strobe;
    irq_event[IRQ_CLR_DONE] = clr_done;
    irq_event[IRQ_EMPTY]    = fifo_empty_i && !empty_q;
  end

  assign irq_clear = (reg_wr_i && reg_addr_i == REG_IRQ_STAT) ? reg_wdata_i[IRQ_W-1:0] : IRQ_ZERO;

  bhf_irq u_irq (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .event_i   (irq_event),
    .clear_i   (irq_clear),
    .mask_i    (irq_mask),
    .status_o  (irq_status),
    .irq_o     (irq_o)
  );

  always_comb
  begin
    next_rdata = WORD_ZERO;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL:     next_rdata[CTRL_DIR_BIT] = fifo_dir_o;
        REG_TXDATA:   next_rdata[BYTE_W-1:0] = tx_byte;
        REG_RXDATA:   next_rdata[BYTE_W-1:0] = rx_byte;
        REG_STATUS:
        begin
          next_rdata[STAT_TX_PEND]  = tx_pending;
          next_rdata[STAT_RX_VALID] = rx_valid;
          next_rdata[STAT_DIR]      = fifo_dir_o;
          next_rdata[STAT_CLEARING] = clearing;
          next_rdata[STAT_EMPTY]    = fifo_empty_i;
          next_rdata[STAT_FULL]     = fifo_full_i;
        end
        REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_status;
        REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
        default:      next_rdata = WORD_ZERO;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= WORD_ZERO;
    else
      reg_rdata_o <= next_rdata;
  end

endmodule : bhf_host

// ### src/bhf_hs_port.sv
// bhf_hs_port: two-wire interlocked handshake engine for one fifo port
// assumes pin inputs synchronous to ref_clk_i; role fixed while enabled
`timescale 1ns/1ps
module bhf_hs_port
  import bhf_pkg::*;
(
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  bhf_port_if.engine port
);

  bhf_hs_state_type  state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  gap;
  logic              gap_done;

  assign gap_done = (gap == CNT_ZERO);

  // spacing of acknowledge falls keeps the ack rate at or below its limit
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      gap <= CNT_ZERO;
    else if (state == HS_SETUP && cnt == CNT_ONE)
      gap <= ACK_CYC;
    else if (!gap_done)
      gap <= gap - CNT_ONE;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || !port.enable)
    begin
      state           <= HS_IDLE;
      cnt             <= CNT_ZERO;
      port.ack_n      <= 1'b1;
      port.data_oe    <= 1'b0;
      port.drive_en_n <= 1'b1;
      port.tx_done    <= 1'b0;
      port.rx_strobe  <= 1'b0;
    end
    else
    begin
      port.tx_done   <= 1'b0;
      port.rx_strobe <= 1'b0;
      unique case (state)
        HS_IDLE:
        begin
          if (port.source_role && port.tx_valid && port.line && gap_done)
          begin
            // device shows ready for a byte: present it
            port.data_oe <= 1'b1;
            state        <= HS_SETUP;
            cnt          <= SETUP_CYC;
          end
          else if (!port.source_role && port.rx_ready && !port.line && gap_done)
          begin
            // byte available: turn on the device drivers first
            port.drive_en_n <= 1'b0;
            state           <= HS_SETUP;
            cnt             <= OE_CYC;
          end
        end
        HS_SETUP:
        begin
          if (cnt == CNT_ONE)
          begin
            port.ack_n <= 1'b0;
            state      <= HS_ACK;
          end
          cnt <= cnt - CNT_ONE;
        end
        HS_ACK:
        begin
          if (port.source_role && !port.line)
          begin
            // byte taken; withdraw it so the device may show ready again
            port.ack_n   <= 1'b1;
            port.data_oe <= 1'b0;
            port.tx_done <= 1'b1;
            state        <= HS_IDLE;
          end
          else if (!port.source_role && port.line)
          begin
            port.ack_n      <= 1'b1;
            port.drive_en_n <= 1'b1;
            port.rx_strobe  <= 1'b1;
            state           <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // data words
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      port.data_out <= BYTE_ZERO;
      port.rx_data  <= BYTE_ZERO;
    end
    else
    begin
      if (state == HS_IDLE && port.source_role)
        port.data_out <= port.tx_data;
      if (state == HS_SETUP && cnt == CNT_ONE && !port.source_role)
        port.rx_data <= port.data_in;
    end
  end

endmodule : bhf_hs_port

// ### src/bhf_irq.sv
// bhf_irq: sticky event bits, write-one-to-clear, masked onto one level output
// assumes event pulses and clear bits are single-cycle
`timescale 1ns/1ps
module bhf_irq
  import bhf_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [IRQ_W-1:0] event_i,
  input  wire logic [IRQ_W-1:0] clear_i,
  input  wire logic [IRQ_W-1:0] mask_i,
  output logic      [IRQ_W-1:0] status_o,
  output logic                  irq_o
);

  // a set in the clearing cycle wins
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      status_o <= IRQ_ZERO;
    else
      status_o <= (status_o & ~clear_i) | event_i;
  end

  assign irq_o = |(status_o & mask_i);

endmodule : bhf_irq

// ### src/bhf_pkg.sv
// bhf_pkg: constants, register map and state types of the fifo host controller
// assumes a 50 MHz ref_clk_i and an external 128 x 8 handshake fifo device
package bhf_pkg;

  localparam int CLK_PERIOD_NS   = 20;
  localparam int BYTE_W          = 8;
  localparam int FIFO_DEPTH      = 128;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 8;
  localparam int CNT_W           = 6;

  // pin timing, in ns as printed
  localparam int T_DATA_SETUP_NS = 50;
  localparam int T_OE_DRIVE_NS   = 150;
  localparam int T_ACK_CYCLE_NS  = 1000;
  localparam int T_CLEAR_NS      = 700;

  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OE_CYC    = CNT_W'((T_OE_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACK_CYC   = CNT_W'((T_ACK_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CLEAR_CYC = CNT_W'((T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TXDATA   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RXDATA   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;

  // field positions
  localparam int CTRL_DIR_BIT    = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int STAT_TX_PEND    = 0;
  localparam int STAT_RX_VALID   = 1;
  localparam int STAT_DIR        = 2;
  localparam int STAT_CLEARING   = 3;
  localparam int STAT_EMPTY      = 4;
  localparam int STAT_FULL       = 5;
  localparam int IRQ_W           = 4;
  localparam int IRQ_TX_DONE     = 0;
  localparam int IRQ_RX_AVAIL    = 1;
  localparam int IRQ_CLR_DONE    = 2;
  localparam int IRQ_EMPTY       = 3;

  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_ZERO  = 4'h0;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_SETUP = 3'b010,
    HS_ACK   = 3'b100
  } bhf_hs_state_type;

  typedef enum logic [2:0] {
    CL_IDLE = 3'b001,
    CL_LOW  = 3'b010,
    CL_DIR  = 3'b100
  } bhf_clr_state_type;

endpackage : bhf_pkg

// ### src/bhf_port_if.sv
// bhf_port_if: one fifo port as seen by a handshake engine and the controller top
// assumes the top drives pins of the device from these signals one to one
`timescale 1ns/1ps
interface bhf_port_if;
  logic                        enable;
  logic                        source_role;
  logic                        tx_valid;
  logic [bhf_pkg::BYTE_W-1:0]  tx_data;
  logic                        tx_done;
  logic                        rx_ready;
  logic [bhf_pkg::BYTE_W-1:0]  rx_data;
  logic                        rx_strobe;
  logic                        ack_n;
  logic                        line;
  logic [bhf_pkg::BYTE_W-1:0]  data_in;
  logic [bhf_pkg::BYTE_W-1:0]  data_out;
  logic                        data_oe;
  logic                        drive_en_n;

  modport engine (
    input  enable, source_role, tx_valid, tx_data, rx_ready, line, data_in,
    output tx_done, rx_data, rx_strobe, ack_n, data_out, data_oe, drive_en_n
  );
  modport ctrl (
    output enable, source_role, tx_valid, tx_data, rx_ready, line, data_in,
    input  tx_done, rx_data, rx_strobe, ack_n, data_out, data_oe, drive_en_n
  );
endinterface : bhf_port_if
